// [hw/vpes_defines.svh]
// Offsets, field positions and reset values of the peak and event status block
`ifndef VPES_DEFINES_SVH
`define VPES_DEFINES_SVH

`define VPES_ADDR_VOLTAGE_PEAK_CAPTURE      16'he501
`define VPES_ADDR_EVENT_STATUS_WORD_0    16'he502
`define VPES_ADDR_PULSE_OUTPUT_MODE_REG     16'he610
`define VPES_ADDR_POWER_SIGN_REG     16'he617
`define VPES_ADDR_ACCUMULATION_MODE_REG    16'he701

`define VPES_PEAK_W          24
`define VPES_PEAK_PHASE_LSB  24
`define VPES_STATUS_W        19
`define VPES_POWER_SIGN_REG_W        9
`define VPES_PULSE_OUTPUT_MODE_REG_W        12
`define VPES_ACCUMULATION_MODE_REG_W       8

`define VPES_ST_TOTAL_ACTIVE_HALF_FULL         0
`define VPES_ST_FUND_ACTIVE_HALF_FULL        1
`define VPES_ST_TOTAL_REACTIVE_HALF_FULL         2
`define VPES_ST_FUND_REACTIVE_HALF_FULL        3
`define VPES_ST_APPARENT_HALF_FULL        4
`define VPES_ST_LINE         5
`define VPES_ST_REVAP_LSB    6
`define VPES_ST_SUM1         9
`define VPES_ST_REVRP_LSB    10
`define VPES_ST_SUM2         13
`define VPES_ST_PULSE_LSB    14
`define VPES_ST_DSP          17
`define VPES_ST_SUM3         18

`define VPES_ACC_ACT_SEL     6
`define VPES_ACC_REACT_SEL   7
`define VPES_CF_DIS_LSB      9

`define VPES_ACCUMULATION_MODE_REG_RST     8'h00
`define VPES_PULSE_OUTPUT_MODE_REG_RST      12'h088

`define VPES_BYTES_WORD      3'h4
`define VPES_BYTES_HALF      3'h2
`define VPES_BYTES_BYTE      3'h1

`endif

// [hw/vpes_pkg.sv]
// Types shared by the peak and event status block
package vpes_pkg;
  typedef enum logic [2:0] {
    VPES_K_U32  = 3'b000,
    VPES_K_SE24 = 3'b001,
    VPES_K_ZP24 = 3'b010,
    VPES_K_ZP20 = 3'b011,
    VPES_K_ZP10 = 3'b100,
    VPES_K_U8   = 3'b101
  } vpes_kind_t;
endpackage

// [hw/vpes_fmt_if.sv]
// Carrier between the register core and the serial word formatter
interface vpes_fmt_if;
  import vpes_pkg::*;
  logic              req;
  logic [31:0]       raw;
  vpes_kind_t        kind;
  logic              valid;
  logic [31:0]       word;
  logic [2:0]        bytes;
  modport core (output req, output raw, output kind, input valid, input word, input bytes);
  modport fmt  (input req, input raw, input kind, output valid, output word, output bytes);
endinterface

// [hw/vpes_word_format.sv]
// Serial word formatter: widens register contents to the transfer word
`include "vpes_defines.svh"
module vpes_word_format (
  input wire logic core_clk,
  input wire logic reset,
  vpes_fmt_if.fmt  port
);
  import vpes_pkg::*;

  logic [31:0] next_word;
  logic [2:0]  next_bytes;

  always_comb begin
    next_word  = port.raw;
    next_bytes = `VPES_BYTES_WORD;
    case (port.kind)
      // R17 sign extend
      VPES_K_SE24: next_word = {{8{port.raw[23]}}, port.raw[23:0]};
      // R17 zero pad
      VPES_K_ZP24: next_word = {8'h00, port.raw[23:0]};
      VPES_K_ZP20: next_word = {12'h000, port.raw[19:0]};
      // R18 sixteen bit pad
      VPES_K_ZP10: begin
        next_word  = {16'h0000, 6'h00, port.raw[9:0]};
        next_bytes = `VPES_BYTES_HALF;
      end
      VPES_K_U8: begin
        next_word  = {24'h000000, port.raw[7:0]};
        next_bytes = `VPES_BYTES_BYTE;
      end
      default: next_word = port.raw;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      port.valid <= 1'b0;
      port.word  <= 32'h00000000;
      port.bytes <= `VPES_BYTES_WORD;
    end else begin
      port.valid <= port.req;
      if (port.req) begin
        port.word  <= next_word;
        port.bytes <= next_bytes;
      end
    end
  end

  AST_SIGN_EXTEND: assert property (@(posedge core_clk) disable iff (reset) // R17
    port.req && port.kind == VPES_K_SE24 |=> port.word[31:24] == {8{$past(port.raw[23])}})
    else $error("sign extension of 24-bit word wrong");
  AST_ZERO_PAD: assert property (@(posedge core_clk) disable iff (reset) // R17
    port.req && port.kind == VPES_K_ZP20 |=> port.word[31:20] == 12'h000 && port.valid)
    else $error("20-bit word not zero padded");
  AST_TEN_BIT: assert property (@(posedge core_clk) disable iff (reset) // R18
    port.req && port.kind == VPES_K_ZP10
    |=> port.word[15:10] == 6'h00 && port.bytes == `VPES_BYTES_HALF
        && port.word[9:0] == $past(port.raw[9:0]))
    else $error("10-bit word not sent as padded 16-bit word");
endmodule

// [hw/vpes_status_top.sv]
// Voltage peak capture, event status word and pulse output selection
//
// Behaviour
// R1: Low 24 bits hold latest voltage peak
// R2: Bits 24-26 flag phase of peak
// R3: Peak register top five bits read zero
// R4: Bit 0 on total active bit30 change
// R5: Bit 1 fundamental active; zero without fundamental
// R6: Bit 2 total reactive; zero without reactive
// R7: Bit 3 fundamental reactive; zero without fundamental
// R8: Bit 4 on apparent energy bit30 change
// R9: Bit 5 at line cycle accumulation end
// R10: Bits 6-8 active sign flip, sign stored
// R11: Bits 10-12 reactive sign flip, selectable source
// R12: Bits 9,13,18 pulse path sum flips
// R13: Bits 14-16 on pulse falling edge, even disabled
// R14: Three-bit select per pulse output
// R15: Bit 17 when periodic computations finish
// R16: Status bits 31:19 read zero
// R17: 24-bit words widened: sign extended or padded
// R18: 10-bit words sent padded to sixteen
// R19: Flags sticky until host clears; reset zero
`include "vpes_defines.svh"
module vpes_status_top #(
  parameter bit HAS_FUND     = 1'b1,
  parameter bit HAS_REACTIVE = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        peakValid,
  input  wire logic [23:0] peakValue,
  input  wire logic [2:0]  peakPhase,
  input  wire logic [14:0] energyBit30,
  input  wire logic        lineCycleMode,
  input  wire logic        lineCycleDone,
  input  wire logic [2:0]  totalActiveSign,
  input  wire logic [2:0]  fundActiveSign,
  input  wire logic [2:0]  totalReactiveSign,
  input  wire logic [2:0]  fundReactiveSign,
  input  wire logic [2:0]  pulseSumSign,
  input  wire logic [7:0]  powerPulse_n,
  input  wire logic        dspCycleDone,
  input  wire logic        rdEn,
  input  wire logic [15:0] rdAddr,
  input  wire logic        wrEn,
  input  wire logic [15:0] wrAddr,
  input  wire logic [31:0] wrData,
  output logic             rdValid,
  output logic [31:0]      rdData,
  output logic [2:0]       rdBytes,
  output logic [2:0]       pulseOutput_n
);
  import vpes_pkg::*;

  function automatic logic vpes_any(input logic [2:0] v);
    return |v;
  endfunction

  function automatic logic vpes_pick(input logic [7:0] src, input logic [2:0] sel);
    return src[sel];
  endfunction

  logic [`VPES_PEAK_W-1:0]    voltagePeakValue;
  logic [2:0]                 voltagePeakPhaseFlags;
  logic [`VPES_STATUS_W-1:0]  eventStatus;
  logic [`VPES_ACCUMULATION_MODE_REG_W-1:0] accumulationMode;
  logic [`VPES_PULSE_OUTPUT_MODE_REG_W-1:0]  pulseOutputMode;
  logic [`VPES_POWER_SIGN_REG_W-1:0]  powerSign;
  logic [14:0]                prevBit30;
  logic [2:0]                 prevPulse;

  vpes_fmt_if fmtLink ();

  // Peak capture
  always_ff @(posedge core_clk) begin
    if (reset) begin
      voltagePeakValue      <= 24'h000000;
      voltagePeakPhaseFlags <= 3'h0;
    end else if (peakValid) begin
      // R1 peak value latch
      voltagePeakValue      <= peakValue;
      // R2 phase flags latch
      voltagePeakPhaseFlags <= peakPhase;
    end
  end

  // Half-full detection
  wire [14:0] bit30Change = energyBit30 ^ prevBit30;

  // Sign sources; a change of source can itself look like a flip
  wire [2:0] activeSignNow   = accumulationMode[`VPES_ACC_ACT_SEL] ? fundActiveSign
                                                                   : totalActiveSign;
  wire [2:0] reactiveSignSel = accumulationMode[`VPES_ACC_REACT_SEL] ? fundReactiveSign
                                                                     : totalReactiveSign;
  wire [2:0] reactiveSignNow = HAS_REACTIVE ? reactiveSignSel : 3'h0;
  wire [`VPES_POWER_SIGN_REG_W-1:0] next_powerSign = {pulseSumSign[2], pulseSumSign[1],
                                              reactiveSignNow, pulseSumSign[0], activeSignNow};
  wire [`VPES_POWER_SIGN_REG_W-1:0] signFlip = next_powerSign ^ powerSign;

  // Pulse outputs
  wire [2:0] pulseNow;
  wire [2:0] pulseDisable = pulseOutputMode[`VPES_CF_DIS_LSB+2:`VPES_CF_DIS_LSB];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pulse
      // R14 power type select
      assign pulseNow[gi] = vpes_pick(powerPulse_n, pulseOutputMode[3*gi+2:3*gi]);
    end
  endgenerate
  wire [2:0] pulseFall = prevPulse & ~pulseNow;

  // Event set vector
  logic [`VPES_STATUS_W-1:0] statusSet;
  always_comb begin
    statusSet = '0;
    // R4 total active
    statusSet[`VPES_ST_TOTAL_ACTIVE_HALF_FULL]  = vpes_any(bit30Change[2:0]);
    // R5 fundamental active
    statusSet[`VPES_ST_FUND_ACTIVE_HALF_FULL] = HAS_FUND && vpes_any(bit30Change[5:3]);
    // R6 total reactive
    statusSet[`VPES_ST_TOTAL_REACTIVE_HALF_FULL]  = HAS_REACTIVE && vpes_any(bit30Change[8:6]);
    // R7 fundamental reactive
    statusSet[`VPES_ST_FUND_REACTIVE_HALF_FULL] = HAS_FUND && vpes_any(bit30Change[11:9]);
    // R8 apparent energy
    statusSet[`VPES_ST_APPARENT_HALF_FULL] = vpes_any(bit30Change[14:12]);
    // R9 line cycle end
    statusSet[`VPES_ST_LINE]  = lineCycleMode && lineCycleDone;
    // R10 active sign flips
    statusSet[`VPES_ST_REVAP_LSB+2:`VPES_ST_REVAP_LSB] = signFlip[2:0];
    // R12 sum sign flips
    statusSet[`VPES_ST_SUM1]  = signFlip[3];
    statusSet[`VPES_ST_SUM2]  = signFlip[7];
    statusSet[`VPES_ST_SUM3]  = signFlip[8];
    // R11 reactive sign flips
    statusSet[`VPES_ST_REVRP_LSB+2:`VPES_ST_REVRP_LSB] = signFlip[6:4];
    // R13 falling edge, ignores disable
    statusSet[`VPES_ST_PULSE_LSB+2:`VPES_ST_PULSE_LSB] = pulseFall;
    // R15 computation done
    statusSet[`VPES_ST_DSP]   = dspCycleDone;
  end

  // Write decode
  wire wrStatus  = wrEn && wrAddr == `VPES_ADDR_EVENT_STATUS_WORD_0;
  wire wrAccMode = wrEn && wrAddr == `VPES_ADDR_ACCUMULATION_MODE_REG;
  wire wrCfMode  = wrEn && wrAddr == `VPES_ADDR_PULSE_OUTPUT_MODE_REG;
  wire [`VPES_STATUS_W-1:0] statusClear = wrStatus ? wrData[`VPES_STATUS_W-1:0] : '0;
  // R19 set beats clear
  wire [`VPES_STATUS_W-1:0] next_eventStatus = (eventStatus & ~statusClear) | statusSet;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      eventStatus      <= '0;
      accumulationMode <= `VPES_ACCUMULATION_MODE_REG_RST;
      pulseOutputMode  <= `VPES_PULSE_OUTPUT_MODE_REG_RST;
      powerSign        <= '0;
      prevBit30        <= '0;
      prevPulse        <= 3'h7;
      pulseOutput_n    <= 3'h7;
    end else begin
      eventStatus      <= next_eventStatus;
      powerSign        <= next_powerSign;
      prevBit30        <= energyBit30;
      prevPulse        <= pulseNow;
      // Disabled outputs idle high, the flag still follows the datapath
      pulseOutput_n    <= pulseNow | pulseDisable;
      if (wrAccMode) begin
        accumulationMode <= wrData[`VPES_ACCUMULATION_MODE_REG_W-1:0];
      end
      if (wrCfMode) begin
        pulseOutputMode <= wrData[`VPES_PULSE_OUTPUT_MODE_REG_W-1:0];
      end
    end
  end

  // Read decode
  logic [31:0] readRaw;
  vpes_kind_t  readKind;
  always_comb begin
    readRaw  = 32'h00000000;
    readKind = VPES_K_U32;
    if (rdAddr == `VPES_ADDR_VOLTAGE_PEAK_CAPTURE) begin
      // R3 top bits zero
      readRaw = {5'h00, voltagePeakPhaseFlags, voltagePeakValue};
    end else if (rdAddr == `VPES_ADDR_EVENT_STATUS_WORD_0) begin
      // R16 reserved bits zero
      readRaw = {13'h0000, eventStatus};
    end else if (rdAddr == `VPES_ADDR_ACCUMULATION_MODE_REG) begin
      readRaw  = {24'h000000, accumulationMode};
      readKind = VPES_K_U8;
    end else if (rdAddr == `VPES_ADDR_PULSE_OUTPUT_MODE_REG) begin
      readRaw  = {20'h00000, pulseOutputMode};
      readKind = VPES_K_ZP10;
      if (pulseOutputMode[11:10] != 2'h0) begin
        readRaw  = {20'h00000, pulseOutputMode};
        readKind = VPES_K_ZP20;
      end
    end else if (rdAddr == `VPES_ADDR_POWER_SIGN_REG) begin
      readRaw  = {23'h000000, powerSign};
      readKind = VPES_K_ZP10;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fmtLink.req  <= 1'b0;
      fmtLink.raw  <= 32'h00000000;
      fmtLink.kind <= VPES_K_U32;
    end else begin
      fmtLink.req <= rdEn;
      if (rdEn) begin
        fmtLink.raw  <= readRaw;
        fmtLink.kind <= readKind;
      end
    end
  end

  vpes_word_format u_format (
    .core_clk (core_clk),
    .reset    (reset),
    .port     (fmtLink.fmt)
  );

  assign rdValid = fmtLink.valid;
  assign rdData  = fmtLink.word;
  assign rdBytes = fmtLink.bytes;

  AST_PEAK_VALUE: assert property (@(posedge core_clk) disable iff (reset) // R1
    peakValid ##1 !peakValid ##1 rdEn && rdAddr == `VPES_ADDR_VOLTAGE_PEAK_CAPTURE && !peakValid
    |-> ##2 rdValid && rdData[23:0] == $past(peakValue, 4))
    else $error("peak value not returned");
  AST_PEAK_PHASE: assert property (@(posedge core_clk) disable iff (reset) // R2
    peakValid |=> voltagePeakPhaseFlags == $past(peakPhase))
    else $error("peak phase flags not captured");
  AST_PEAK_TOP: assert property (@(posedge core_clk) disable iff (reset) // R3
    rdEn && rdAddr == `VPES_ADDR_VOLTAGE_PEAK_CAPTURE |-> ##2 rdValid && rdData[31:27] == 5'h00)
    else $error("peak register top bits nonzero");
  AST_ACTIVE_HALF: assert property (@(posedge core_clk) disable iff (reset) // R4
    energyBit30[2:0] != prevBit30[2:0] |=> eventStatus[`VPES_ST_TOTAL_ACTIVE_HALF_FULL])
    else $error("active half-full flag missed");
  AST_FUND_ABSENT: assert property (@(posedge core_clk) disable iff (reset) // R5
    !HAS_FUND |-> !eventStatus[`VPES_ST_FUND_ACTIVE_HALF_FULL] && !eventStatus[`VPES_ST_FUND_REACTIVE_HALF_FULL])
    else $error("fundamental flag set in variant without it");
  AST_REACT_ABSENT: assert property (@(posedge core_clk) disable iff (reset) // R11
    !HAS_REACTIVE |-> eventStatus[12:10] == 3'h0 && !eventStatus[`VPES_ST_TOTAL_REACTIVE_HALF_FULL])
    else $error("reactive flag set in variant without it");
  AST_LINE_DONE: assert property (@(posedge core_clk) disable iff (reset) // R9
    lineCycleDone && !lineCycleMode && !$past(eventStatus[`VPES_ST_LINE]) && !wrStatus
    |=> !eventStatus[`VPES_ST_LINE] || $past(eventStatus[`VPES_ST_LINE]))
    else $error("line flag set outside line mode");
  AST_ACT_FLIP: assert property (@(posedge core_clk) disable iff (reset) // R10
    $stable(accumulationMode) && !accumulationMode[`VPES_ACC_ACT_SEL]
    && totalActiveSign != $past(totalActiveSign)
    |=> (eventStatus[8:6] & ($past(totalActiveSign) ^ $past(totalActiveSign, 2))) != 3'h0)
    else $error("active sign flip not flagged");
  AST_PULSE_FLAG: assert property (@(posedge core_clk) disable iff (reset) // R13
    prevPulse[0] && !pulseNow[0] |=> eventStatus[`VPES_ST_PULSE_LSB])
    else $error("pulse edge not flagged");
  AST_PULSE_SELECT: assert property (@(posedge core_clk) disable iff (reset) // R14
    !pulseOutputMode[`VPES_CF_DIS_LSB+1]
    |=> pulseOutput_n[1] == $past(powerPulse_n[pulseOutputMode[5:3]]))
    else $error("pulse output 2 does not follow selected power");
  AST_DSP_DONE: assert property (@(posedge core_clk) disable iff (reset) // R15
    dspCycleDone |=> eventStatus[`VPES_ST_DSP])
    else $error("computation done flag missed");
  AST_STATUS_RSVD: assert property (@(posedge core_clk) disable iff (reset) // R16
    rdEn && rdAddr == `VPES_ADDR_EVENT_STATUS_WORD_0 |-> ##2 rdValid && rdData[31:19] == 13'h0000)
    else $error("reserved status bits nonzero");
  AST_STICKY: assert property (@(posedge core_clk) disable iff (reset) // R19
    eventStatus[`VPES_ST_DSP] && !(wrStatus && wrData[`VPES_ST_DSP])
    |=> eventStatus[`VPES_ST_DSP])
    else $error("status flag dropped without clear");
  AST_STATUS_CLEAR: assert property (@(posedge core_clk) disable iff (reset) // R19
    wrStatus && wrData[`VPES_ST_DSP] && !dspCycleDone |=> !eventStatus[`VPES_ST_DSP])
    else $error("status flag not cleared by host write");
  AST_LINE_SET: assert property (@(posedge core_clk) disable iff (reset) // R9
    lineCycleMode && lineCycleDone |=> eventStatus[`VPES_ST_LINE])
    else $error("line cycle completion not flagged");
  AST_APPARENT_HALF: assert property (@(posedge core_clk) disable iff (reset) // R8
    energyBit30[14:12] != prevBit30[14:12] |=> eventStatus[`VPES_ST_APPARENT_HALF_FULL])
    else $error("apparent half-full flag missed");
  AST_REACT_HALF: assert property (@(posedge core_clk) disable iff (reset) // R6
    HAS_REACTIVE && energyBit30[8:6] != prevBit30[8:6] |=> eventStatus[`VPES_ST_TOTAL_REACTIVE_HALF_FULL])
    else $error("reactive half-full flag missed");
  AST_FUND_HALF: assert property (@(posedge core_clk) disable iff (reset) // R7
    HAS_FUND && energyBit30[11:9] != prevBit30[11:9] |=> eventStatus[`VPES_ST_FUND_REACTIVE_HALF_FULL])
    else $error("fundamental reactive half-full flag missed");
  AST_SUM1_FLIP: assert property (@(posedge core_clk) disable iff (reset) // R12
    pulseSumSign[0] != $past(pulseSumSign[0]) |=> eventStatus[`VPES_ST_SUM1])
    else $error("pulse path 1 sum flip not flagged");
  AST_SUM3_FLIP: assert property (@(posedge core_clk) disable iff (reset) // R12
    pulseSumSign[2] != $past(pulseSumSign[2]) |=> eventStatus[`VPES_ST_SUM3])
    else $error("pulse path 3 sum flip not flagged");
  AST_SIGN_STORE: assert property (@(posedge core_clk) disable iff (reset) // R10
    !accumulationMode[`VPES_ACC_ACT_SEL] |=> powerSign[2:0] == $past(totalActiveSign))
    else $error("active sign not stored");
  AST_REACT_FLIP: assert property (@(posedge core_clk) disable iff (reset) // R11
    HAS_REACTIVE && $stable(accumulationMode) && accumulationMode[`VPES_ACC_REACT_SEL]
    && fundReactiveSign != $past(fundReactiveSign)
    |=> (eventStatus[12:10] & ($past(fundReactiveSign) ^ $past(fundReactiveSign, 2))) != 3'h0)
    else $error("reactive sign flip not flagged");
  AST_PULSE_DISABLED: assert property (@(posedge core_clk) disable iff (reset) // R13
    pulseOutputMode[`VPES_CF_DIS_LSB+2] && prevPulse[2] && !pulseNow[2]
    |=> eventStatus[`VPES_ST_PULSE_LSB+2] && pulseOutput_n[2])
    else $error("disabled pulse output edge not flagged");
  AST_PEAK_HOLD: assert property (@(posedge core_clk) disable iff (reset) // R2
    !peakValid |=> $stable(voltagePeakValue) && $stable(voltagePeakPhaseFlags))
    else $error("peak register changed without new peak");
endmodule

// [test/vpes_status_top_tb.sv]
// Self-checking bench for the voltage peak and event status block
`include "vpes_defines.svh"
module vpes_status_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] aPeak = `VPES_ADDR_VOLTAGE_PEAK_CAPTURE;
  localparam logic [15:0] aStat = `VPES_ADDR_EVENT_STATUS_WORD_0;
  localparam logic [15:0] aAcc  = `VPES_ADDR_ACCUMULATION_MODE_REG;
  localparam logic [15:0] aCf   = `VPES_ADDR_PULSE_OUTPUT_MODE_REG;
  localparam logic [15:0] aSign = `VPES_ADDR_POWER_SIGN_REG;
  logic        core_clk          = 1'b0;
  logic        reset             = 1'b1;
  logic        peakValid         = 1'b0;
  logic [23:0] peakValue         = 24'h0;
  logic [2:0]  peakPhase         = 3'h0;
  logic [14:0] energyBit30       = 15'h0;
  logic        lineCycleMode     = 1'b0;
  logic        lineCycleDone     = 1'b0;
  logic [2:0]  totalActiveSign   = 3'h0;
  logic [2:0]  fundActiveSign    = 3'h0;
  logic [2:0]  totalReactiveSign = 3'h0;
  logic [2:0]  fundReactiveSign  = 3'h0;
  logic [2:0]  pulseSumSign      = 3'h0;
  logic [7:0]  powerPulse_n      = 8'hff;
  logic        dspCycleDone      = 1'b0;
  logic        rdEn              = 1'b0;
  logic [15:0] rdAddr            = 16'h0;
  logic        wrEn              = 1'b0;
  logic [15:0] wrAddr            = 16'h0;
  logic [31:0] wrData            = 32'h0;
  wire         rdValid;
  wire  [31:0] rdData;
  wire  [2:0]  rdBytes;
  wire  [2:0]  pulseOutput_n;
  int          fails             = 0;
  int          checks            = 0;
  int          cycles            = 0;
  int          mStatus           = 0;
  int          mPeak             = 0;
  int          mSign             = 0;
  int          mAcc              = 0;
  int          mE                = 0;

  vpes_status_top uut (
    .core_clk, .reset, .peakValid, .peakValue, .peakPhase, .energyBit30,
    .lineCycleMode, .lineCycleDone, .totalActiveSign, .fundActiveSign,
    .totalReactiveSign, .fundReactiveSign, .pulseSumSign, .powerPulse_n,
    .dspCycleDone, .rdEn, .rdAddr, .wrEn, .wrAddr, .wrData, .rdValid,
    .rdData, .rdBytes, .pulseOutput_n
  );

  always #20 core_clk = ~core_clk;

  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Read answers exactly two cycles after the take edge
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [2:0] nb);
    int n;
    @(posedge core_clk);
    rdEn   <= 1'b1;
    rdAddr <= a;
    @(posedge core_clk);
    rdEn <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rdValid !== 1'b1 && n < 4);
    cmp(n, 2, "latency");
    cmp(rdData, exp, "data");
    cmp({29'h0, rdBytes}, {29'h0, nb}, "bytes");
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wrEn   <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    @(posedge core_clk);
    wrEn <= 1'b0;
    case (a)
      aAcc:    mAcc = d[7:0];
      aStat:   mStatus &= ~d;
      default: ;
    endcase
  endtask

  task automatic peak(input logic [23:0] v, input logic [2:0] p);
    @(posedge core_clk);
    peakValid <= 1'b1;
    peakValue <= v;
    peakPhase <= p;
    @(posedge core_clk);
    peakValid <= 1'b0;
    mPeak = {5'h0, p, v};
  endtask

  // Model of sign flips and half-full events after inputs have settled
  task automatic eval();
    logic [8:0]  ns;
    logic [8:0]  df;
    logic [14:0] de;
    repeat (3) @(posedge core_clk);
    ns = {pulseSumSign[2], pulseSumSign[1], mAcc[7] ? fundReactiveSign : totalReactiveSign,
          pulseSumSign[0], mAcc[6] ? fundActiveSign : totalActiveSign};
    df = ns ^ mSign[8:0];
    de = energyBit30 ^ mE[14:0];
    mStatus |= {df[8], 4'h0, df[7], df[6:4], df[3], df[2:0], 1'b0,
                |de[14:12], |de[11:9], |de[8:6], |de[5:3], |de[2:0]};
    mSign = ns;
    mE = energyBit30;
  endtask

  initial begin
    logic [11:0] cf;
    void'($urandom(52));
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd(aPeak, 0, 3'h4);
    rd(aStat, 0, 3'h4);
    rd(aAcc, 0, 3'h1);
    rd(aCf, 32'h88, 3'h2);
    rd(aSign, 0, 3'h2);
    rd(16'he5ff, 0, 3'h4);
    for (int k = 0; k < 3; k++) begin
      peak(k == 0 ? 24'hffffff : 24'($urandom), 3'(1 << ($urandom % 3)));
      rd(aPeak, mPeak, 3'h4);
    end
    wr(aPeak, 32'hffffffff);
    rd(aPeak, mPeak, 3'h4);
    // Walk every accumulator bit so each group maps to its own flag
    for (int j = 0; j < 15; j++) begin
      @(posedge core_clk);
      energyBit30 <= energyBit30 ^ (15'h1 << j);
      eval();
      rd(aStat, mStatus, 3'h4);
      wr(aStat, 32'hffffffff);
    end
    for (int j = 0; j < 12; j++) begin
      if (j == 6) begin
        wr(aAcc, 32'hc0);
        eval();
        rd(aAcc, 32'hc0, 3'h1);
      end
      @(posedge core_clk);
      {totalActiveSign, fundActiveSign, totalReactiveSign, fundReactiveSign,
       pulseSumSign} <= 15'($urandom);
      eval();
      rd(aStat, mStatus, 3'h4);
      rd(aSign, mSign, 3'h2);
      wr(aStat, 32'hffffffff);
    end
    wr(aSign, 32'h1ff);
    rd(aSign, mSign, 3'h2);
    // Every select code once on output 1, random on the others
    for (int t = 0; t < 8; t++) begin
      cf = {3'($urandom), 3'($urandom), 3'($urandom), 3'(t)};
      wr(aCf, {20'h0, cf});
      rd(aCf, cf[11:10] == 2'b00 ? {22'h0, cf[9:0]} : {20'h0, cf},
         cf[11:10] == 2'b00 ? 3'h2 : 3'h4);
      @(posedge core_clk);
      powerPulse_n <= ~(8'h01 << t);
      repeat (2) @(posedge core_clk);
      #1;
      for (int i = 0; i < 3; i++)
        cmp({31'h0, pulseOutput_n[i]}, cf[3*i +: 3] == t ? cf[9+i] : 1'b1, "pin");
      @(posedge core_clk);
      powerPulse_n <= 8'hff;
      for (int i = 0; i < 3; i++)
        if (cf[3*i +: 3] == t) mStatus |= 1 << (14 + i);
      rd(aStat, mStatus, 3'h4);
      wr(aStat, 32'hffffffff);
    end
    // Line-cycle completion counts only in its mode
    for (int j = 0; j < 2; j++) begin
      @(posedge core_clk);
      lineCycleMode <= j[0];
      lineCycleDone <= 1'b1;
      dspCycleDone  <= j[0];
      @(posedge core_clk);
      lineCycleDone <= 1'b0;
      dspCycleDone  <= 1'b0;
      if (j == 1) mStatus |= 32'h20020;
      rd(aStat, mStatus, 3'h4);
    end
    repeat (10) @(posedge core_clk);
    rd(aStat, mStatus, 3'h4);
    wr(aStat, 32'h20);
    rd(aStat, mStatus, 3'h4);
    wrap_up();
  end
endmodule
